// ### hw/tpbr_pkg.sv
// Shared constants and carrier types for the two-port block memory
package tpbr_pkg;

	// Array geometry
	localparam int ADDR_W = 9;
	localparam int HALF_W = 9;
	localparam int DATA_W = 18;
	localparam int WORDS = 512;
	localparam int PRELOAD_TOTAL = 4608;
	localparam int PRELOAD_CNT_W = 13;

	// Width selector codes
	localparam logic [1:0] WIDTH_NARROW = 2'h1;
	localparam logic [1:0] WIDTH_WIDE = 2'h2;

	// Reset values, narrow-read upper fill, last bit index of a word
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
	localparam logic [HALF_W-1:0] UPPER_UNDEF = 9'h000;
	localparam logic [PRELOAD_CNT_W-1:0] PRELOAD_CNT_RST = 13'h0000;
	localparam logic [3:0] BIT_LAST = 4'h8;

	// Preload sequencer states
	typedef enum logic [1:0] {
		TPBR_PL_IDLE = 2'b01,
		TPBR_PL_SHIFT = 2'b10
	} tpbr_pl_state_t;

	// Write port request
	typedef struct packed {
		logic clock;
		logic enable;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] data;
	} tpbr_wr_port_t;

	// Read port request
	typedef struct packed {
		logic clock;
		logic enable;
		logic [ADDR_W-1:0] address;
	} tpbr_rd_port_t;

	// Per-port static configuration
	typedef struct packed {
		logic [1:0] width;
		logic enable_active_high;
		logic clock_falling;
	} tpbr_port_cfg_t;

endpackage

// ### hw/tpbr_ram.sv
// Two-port block memory, 512x9 or 256x18 per port, with serial preload
//
// Functional notes
// - Independent write and read ports
// - Width code 01 is 512x9, 10 is 256x18
// - Write data and read data are 18 bits
// - Narrow read: upper read bits are zero
// - Both addresses are nine bits wide
// - Each port runs on its own clock
// - Enables active low, polarity configurable
// - Reset zeroes output, blocks access, clears holds
// - Reset never touches stored array contents
// - Pipeline select chooses same or next cycle
// - Flow-through read: address captured, data follows
// - Pipelined read: data after second read edge
// - Enabled write edge stores data at address
// - Either clock edge selectable by inversion
// - Serial preload loads all array bits
`timescale 1ns/10ps

module tpbr_ram #(
	parameter int PRELOAD_BITS = tpbr_pkg::PRELOAD_TOTAL
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Write port
	input wire tpbr_pkg::tpbr_wr_port_t write_port,
	input wire logic [1:0] write_width_select,
	input wire logic write_enable_active_high,
	input wire logic write_clock_falling,
	// Read port
	input wire tpbr_pkg::tpbr_rd_port_t read_port,
	input wire logic [1:0] read_width_select,
	input wire logic read_enable_active_high,
	input wire logic read_clock_falling,
	input wire logic pipeline_select,
	output logic [tpbr_pkg::DATA_W-1:0] read_data_bus,
	// Serial preload
	input wire logic preload_start,
	input wire logic preload_shift,
	input wire logic preload_bit,
	output logic preload_busy,
	output logic preload_done,
	// Status
	output logic collision_flag,
	output logic config_error
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Word-pair index touched by an access of the given width
	function automatic logic [7:0] pair_index(input logic [1:0] width,
		input logic [tpbr_pkg::ADDR_W-1:0] addr);
		pair_index = (width == tpbr_pkg::WIDTH_WIDE) ? addr[7:0] : addr[8:1];
	endfunction

	// Active clock edge of a port pin, rising or falling by choice
	function automatic logic clock_edge(input logic prev, input logic cur,
		input logic falling);
		clock_edge = falling ? (prev & ~cur) : (~prev & cur);
	endfunction

	// Width code is one of the two legal ones
	function automatic logic width_ok(input logic [1:0] width);
		width_ok = (width == tpbr_pkg::WIDTH_NARROW) ||
			(width == tpbr_pkg::WIDTH_WIDE);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Storage and state

	// Array of nine-bit words, one per nine-bit address
	logic [tpbr_pkg::HALF_W-1:0] mem [tpbr_pkg::WORDS];

	// Previous samples of the two port clock pins
	logic wclk_prev_reg;
	logic rclk_prev_reg;

	// Read path hold stage and output next values
	logic [tpbr_pkg::DATA_W-1:0] stage_reg;
	logic [tpbr_pkg::DATA_W-1:0] stage_next;
	logic [tpbr_pkg::DATA_W-1:0] read_data_next;

	// Last write, kept for the one-cycle collision window
	logic write_seen_reg;
	logic [7:0] write_pair_reg;
	logic write_low_reg;
	logic write_wide_reg;
	logic collision_next;

	// Serial preload sequencer and its counters
	tpbr_pkg::tpbr_pl_state_t pl_state_reg;
	tpbr_pkg::tpbr_pl_state_t pl_state_next;
	logic [8:0] pl_word_reg;
	logic [3:0] pl_bit_reg;
	logic [tpbr_pkg::PRELOAD_CNT_W-1:0] pl_count_reg;

	////////////////////////////////////////////////////////////////////////
	// Port decode

	wire write_edge = clock_edge(wclk_prev_reg, write_port.clock,
		write_clock_falling);
	wire read_edge = clock_edge(rclk_prev_reg, read_port.clock,
		read_clock_falling);

	// Enable polarity compare and width decode
	wire write_en_on = write_port.enable == write_enable_active_high;
	wire read_en_on = read_port.enable == read_enable_active_high;
	wire write_wide = write_width_select == tpbr_pkg::WIDTH_WIDE;
	wire read_wide = read_width_select == tpbr_pkg::WIDTH_WIDE;
	wire pl_active = pl_state_reg == tpbr_pkg::TPBR_PL_SHIFT;
	wire width_bad = !width_ok(write_width_select) ||
		!width_ok(read_width_select);

	// Access strobes: reserved widths shut a port, preload shuts the write port only
	wire do_write = write_edge && write_en_on && width_ok(write_width_select)
		&& !pl_active;
	wire do_read = read_edge && read_en_on && width_ok(read_width_select);

	// Address bit eight ignored in wide mode
	wire [7:0] wr_pair = write_port.address[7:0];
	wire [7:0] rd_pair = read_port.address[7:0];
	wire [tpbr_pkg::ADDR_W-1:0] wr_lo_addr = {wr_pair, 1'b0};
	wire [tpbr_pkg::ADDR_W-1:0] wr_hi_addr = {wr_pair, 1'b1};
	wire [tpbr_pkg::ADDR_W-1:0] rd_lo_addr = {rd_pair, 1'b0};
	wire [tpbr_pkg::ADDR_W-1:0] rd_hi_addr = {rd_pair, 1'b1};

	// Addressed word, little-endian halves in wide mode
	wire [tpbr_pkg::DATA_W-1:0] array_word = read_wide ?
		{mem[rd_hi_addr], mem[rd_lo_addr]} :
		{tpbr_pkg::UPPER_UNDEF, mem[read_port.address]};

	////////////////////////////////////////////////////////////////////////
	// Read path selection

	always_comb
	begin
		stage_next = stage_reg;
		read_data_next = read_data_bus;
		if (do_read)
		begin
			stage_next = array_word;
			if (pipeline_select)
				read_data_next = stage_reg;
			else
				read_data_next = array_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Collision detection against a write in this or the previous cycle

	wire [7:0] rd_pair_idx = pair_index(read_width_select, read_port.address);
	wire [7:0] wr_pair_idx = pair_index(write_width_select,
		write_port.address);
	wire hit_now = do_write && (wr_pair_idx == rd_pair_idx) &&
		(write_wide || read_wide ||
		write_port.address[0] == read_port.address[0]);
	wire hit_prev = write_seen_reg && (write_pair_reg == rd_pair_idx) &&
		(write_wide_reg || read_wide ||
		write_low_reg == read_port.address[0]);
	assign collision_next = do_read && (hit_now || hit_prev);

	////////////////////////////////////////////////////////////////////////
	// Preload sequencer next state

	// Count of the final preload bit, sized to the counter
	localparam logic [tpbr_pkg::PRELOAD_CNT_W-1:0] PL_LAST_IDX =
		tpbr_pkg::PRELOAD_CNT_W'(PRELOAD_BITS - 1);

	// Last bit of the image is being taken
	wire pl_last = pl_count_reg == PL_LAST_IDX;

	always_comb
	begin
		case (pl_state_reg)
			tpbr_pkg::TPBR_PL_IDLE:
				pl_state_next = preload_start ? tpbr_pkg::TPBR_PL_SHIFT :
					tpbr_pkg::TPBR_PL_IDLE;
			tpbr_pkg::TPBR_PL_SHIFT:
				pl_state_next = (preload_shift && pl_last) ?
					tpbr_pkg::TPBR_PL_IDLE : tpbr_pkg::TPBR_PL_SHIFT;
			default:
				pl_state_next = tpbr_pkg::TPBR_PL_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Clock pin history

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wclk_prev_reg <= 1'b0;
			rclk_prev_reg <= 1'b0;
		end
		else
		begin
			wclk_prev_reg <= write_port.clock;
			rclk_prev_reg <= read_port.clock;
		end
	end

	// Output and hold registers, zeroed by reset
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage_reg <= tpbr_pkg::DATA_RST;
			read_data_bus <= tpbr_pkg::DATA_RST;
		end
		else
		begin
			stage_reg <= stage_next;
			read_data_bus <= read_data_next;
		end
	end

	// Status and last-write memory
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			write_seen_reg <= 1'b0;
			write_pair_reg <= 8'h00;
			write_low_reg <= 1'b0;
			write_wide_reg <= 1'b0;
			collision_flag <= 1'b0;
			config_error <= 1'b0;
		end
		else
		begin
			write_seen_reg <= do_write;
			write_pair_reg <= wr_pair_idx;
			write_low_reg <= write_port.address[0];
			write_wide_reg <= write_wide;
			collision_flag <= collision_next;
			config_error <= width_bad;
		end
	end

	// Preload counters
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pl_state_reg <= tpbr_pkg::TPBR_PL_IDLE;
			pl_word_reg <= 9'h000;
			pl_bit_reg <= 4'h0;
			pl_count_reg <= tpbr_pkg::PRELOAD_CNT_RST;
			preload_busy <= 1'b0;
			preload_done <= 1'b0;
		end
		else
		begin
			pl_state_reg <= pl_state_next;
			preload_busy <= pl_state_next == tpbr_pkg::TPBR_PL_SHIFT;
			preload_done <= pl_active && preload_shift && pl_last;
			if (!pl_active)
			begin
				pl_word_reg <= 9'h000;
				pl_bit_reg <= 4'h0;
				pl_count_reg <= tpbr_pkg::PRELOAD_CNT_RST;
			end
			else if (preload_shift)
			begin
				pl_count_reg <= pl_count_reg + 13'h0001;
				if (pl_bit_reg == tpbr_pkg::BIT_LAST)
				begin
					pl_bit_reg <= 4'h0;
					pl_word_reg <= pl_word_reg + 9'h001;
				end
				else
					pl_bit_reg <= pl_bit_reg + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array writes: no reset, so contents survive it

	always_ff @(posedge clk)
	begin
		if (reset_n && pl_active && preload_shift)
			mem[pl_word_reg][pl_bit_reg] <= preload_bit;
		else if (reset_n && do_write)
		begin
			if (write_wide)
			begin
				mem[wr_lo_addr] <= write_port.data[8:0];
				mem[wr_hi_addr] <= write_port.data[17:9];
			end
			else
				mem[write_port.address] <= write_port.data[8:0];
		end
	end

endmodule // tpbr_ram

// ### tb/tpbr_fabric.sv
// Fabric-side driver of the memory write and read ports
`timescale 1ns/10ps
module tpbr_fabric (
	// Clock and reset
	input logic clk,
	input logic reset_n,
	// Requests from the bench
	input logic wgo,
	input logic rgo,
	input logic [8:0] wa,
	input logic [17:0] wd,
	input logic [8:0] ra,
	input logic [3:0] mode, // w_hi, r_hi, w_wide, r_wide
	// Toward the memory
	output tpbr_pkg::tpbr_wr_port_t wp,
	output tpbr_pkg::tpbr_rd_port_t rp,
	output logic busy,
	output logic rd_done
);
	logic [2:0] cnt_reg;
	logic w_reg, r_reg, d1_reg, d2_reg;
	// One port-clock pulse per request, still in between
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			{cnt_reg, w_reg, r_reg, d1_reg, d2_reg} <= '0;
		else
		begin
			cnt_reg <= cnt_reg == 3'h0 ? {2'h0, wgo | rgo} : cnt_reg + 3'h1;
			if (cnt_reg == 3'h0 && (wgo | rgo))
				{w_reg, r_reg} <= {wgo, rgo};
			{d1_reg, d2_reg} <= {cnt_reg == 3'h7, d1_reg};
		end
	// Enable active only on the chosen port
	assign busy = |{cnt_reg, d1_reg, d2_reg};
	assign rd_done = d2_reg & r_reg;
	assign wp = {cnt_reg[2], w_reg ~^ mode[3],
		mode[1] ? {1'b0, wa[7:0]} : wa,
		mode[1] ? wd : {9'h000, wd[8:0]}};
	assign rp = {cnt_reg[2], r_reg ~^ mode[2],
		mode[0] ? {1'b0, ra[7:0]} : ra};
endmodule // tpbr_fabric

// ### tb/tpbr_ram_checker.sv
// Port-level assertions for the two-port block memory
`timescale 1ns/10ps
module tpbr_ram_checker (
	// Clock and reset
	input logic clk,
	input logic reset_n,
	// Watched ports
	input tpbr_pkg::tpbr_rd_port_t read_port,
	input logic [1:0] write_width_select,
	input logic [1:0] read_width_select,
	input logic read_enable_active_high,
	input logic read_clock_falling,
	input logic [17:0] read_data_bus,
	input logic preload_start,
	input logic preload_busy,
	input logic preload_done,
	input logic collision_flag,
	input logic config_error
);
	logic prev_reg;
	logic rd_ev;
	logic bad_w;
	// Read clock history
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			prev_reg <= 1'b0;
		else
			prev_reg <= read_port.clock;
	// Enabled read event, reserved codes
	assign rd_ev = (read_clock_falling ? prev_reg & ~read_port.clock
		: ~prev_reg & read_port.clock) &
		(read_port.enable == read_enable_active_high) &
		(read_width_select inside {2'h1, 2'h2});
	assign bad_w = !(read_width_select inside {2'h1, 2'h2}) ||
		!(write_width_select inside {2'h1, 2'h2});
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_start;
		preload_start && !preload_busy && !preload_done;
	endsequence
	a_release_zero: assert property ($rose(reset_n) |->
		read_data_bus == 18'h00000) else $error("output not cleared");
	a_idle_hold: assert property (!rd_ev |=> $stable(read_data_bus))
		else $error("output moved");
	a_narrow_top: assert property (rd_ev && read_width_select == 2'h1
		|=> read_data_bus[17:9] == 9'h000) else $error("upper bits set");
	a_busy_start: assert property (s_start |=> preload_busy)
		else $error("no busy");
	a_done_once: assert property (preload_done |=> !preload_done)
		else $error("long done");
	a_busy_end: assert property ($fell(preload_busy) |-> preload_done)
		else $error("no done");
	a_cfg_flag: assert property (bad_w |=> config_error)
		else $error("no config error");
	a_coll_cause: assert property (collision_flag |-> $past(rd_ev))
		else $error("stray collision");
endmodule // tpbr_ram_checker
bind tpbr_ram tpbr_ram_checker u_chk (.clk(clk), .reset_n(reset_n),
	.read_port(read_port), .write_width_select(write_width_select),
	.read_width_select(read_width_select),
	.read_enable_active_high(read_enable_active_high),
	.read_clock_falling(read_clock_falling), .read_data_bus(read_data_bus),
	.preload_start(preload_start), .preload_busy(preload_busy),
	.preload_done(preload_done), .collision_flag(collision_flag),
	.config_error(config_error));

// ### tb/tpbr_ram_test.sv
// Self-checking bench for the two-port block memory
`timescale 1ns/10ps
module tpbr_ram_test;
	logic clk, reset_n, wgo, rgo, busy, rd_done, pipe, pl_start, pl_shift;
	logic pl_bit, pl_busy, pl_done, w_hi, r_hi, w_fall, r_fall;
	logic coll_flag, coll_seen, cfg_err;
	logic [1:0] wws, rws;
	logic [8:0] wa, ra, a;
	logic [17:0] wd, rdata, prev;
	logic [8:0] m [512];
	logic [18:0] q [$];
	logic [18:0] note;
	tpbr_pkg::tpbr_wr_port_t wp;
	tpbr_pkg::tpbr_rd_port_t rp;
	int n_mismatch, tests_run, cyc;
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	tpbr_ram #(.PRELOAD_BITS(18)) uut (.clk(clk), .reset_n(reset_n),
		.write_port(wp), .write_width_select(wws),
		.write_enable_active_high(w_hi), .write_clock_falling(w_fall),
		.read_port(rp), .read_width_select(rws),
		.read_enable_active_high(r_hi), .read_clock_falling(r_fall),
		.pipeline_select(pipe), .read_data_bus(rdata),
		.preload_start(pl_start), .preload_shift(pl_shift),
		.preload_bit(pl_bit), .preload_busy(pl_busy),
		.preload_done(pl_done), .collision_flag(coll_flag),
		.config_error(cfg_err));
	tpbr_fabric fab (.clk(clk), .reset_n(reset_n), .wgo(wgo), .rgo(rgo),
		.wa(wa), .wd(wd), .ra(ra),
		.mode({w_hi, r_hi, wws == 2'h2, rws == 2'h2}),
		.wp(wp), .rp(rp), .busy(busy), .rd_done(rd_done));
	task automatic chk(input string what, input logic [17:0] seen,
		input logic [17:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [17:0] word(input logic [8:0] x);
		return rws == 2'h2 ? {m[{x[7:0], 1'b1}], m[{x[7:0], 1'b0}]}
			: {9'h000, m[x]};
	endfunction
	// One request; a read notes its expected word first
	task automatic xfer(input logic w, input logic r, input logic [8:0] x);
		wa = x;
		ra = x;
		wgo = w;
		rgo = r;
		if (r)
			q.push_back({w, pipe ? prev : word(x)});
		if (r)
			prev = word(x);
		if (w && wws == 2'h2)
			{m[{x[7:0], 1'b1}], m[{x[7:0], 1'b0}]} = wd;
		if (w && wws == 2'h1)
			m[x] = wd[8:0];
		@(negedge clk);
		{wgo, rgo} = 2'h0;
		while (busy)
			@(negedge clk);
	endtask
	task automatic rst;
		reset_n = 1'b0;
		prev = 18'h00000;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Compare each finished read with the oldest note
	always @(negedge clk)
	begin
		if (coll_flag)
			coll_seen = 1'b1;
		if (rd_done)
		begin
			note = q.pop_front();
			chk("read_data_bus", rdata,
				note[17:0]);
			chk("collision_flag", 18'(coll_seen),
				18'(note[18]));
			coll_seen = 1'b0;
		end
	end
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			close_out();
		end
	end
	// Test sequence
	initial
	begin
		{wgo, rgo, pl_start, pl_shift, pl_bit, pipe, coll_seen} = '0;
		{w_hi, r_hi, w_fall, r_fall, wa, ra, wd} = '0;
		wws = 2'h2;
		rws = 2'h2;
		void'($urandom(88626));
		rst();
		repeat (6)
		begin
			a = 9'($urandom);
			wd = 18'($urandom);
			xfer(1'b1, 1'b0, a);
			xfer(1'b0, 1'b1, a);
		end
		wd = ~wd;
		xfer(1'b1, 1'b1, a);
		xfer(1'b0, 1'b1, a);
		$display("test wide done");
		wws = 2'h1;
		rws = 2'h1;
		repeat (4)
		begin
			a = 9'($urandom);
			wd = 18'($urandom);
			xfer(1'b1, 1'b0, {a[8:1], 1'b0});
			wd = ~wd;
			xfer(1'b1, 1'b0, {a[8:1], 1'b1});
			xfer(1'b0, 1'b1, a);
		end
		rws = 2'h2;
		xfer(1'b0, 1'b1, {1'b0, a[8:1]});
		$display("test narrow done");
		wws = 2'h2;
		{w_hi, r_hi, w_fall, r_fall} = 4'hF;
		repeat (3)
		begin
			a = 9'($urandom);
			wd = 18'($urandom);
			xfer(1'b1, 1'b0, a);
			wd = ~wd;
			xfer(1'b1, 1'b0, ~a);
			xfer(1'b0, 1'b1, a);
		end
		$display("test polarity done");
		pipe = 1'b1;
		rst();
		xfer(1'b0, 1'b1, a);
		xfer(1'b0, 1'b1, ~a);
		xfer(1'b0, 1'b1, a);
		pipe = 1'b0;
		$display("test reset done");
		wws = 2'h0;
		xfer(1'b1, 1'b0, a);
		chk("config_error", 18'(cfg_err), 18'h00001);
		wws = 2'h2;
		xfer(1'b0, 1'b1, a);
		chk("config_error", 18'(cfg_err), 18'h00000);
		$display("test reserved done");
		pl_start = 1'b1;
		@(negedge clk);
		pl_start = 1'b0;
		chk("preload_busy", 18'(pl_busy), 18'h00001);
		pl_shift = 1'b1;
		for (int i = 0; i < 18; i++)
		begin
			pl_bit = 1'($urandom);
			m[i / 9][i % 9] = pl_bit;
			@(negedge clk);
		end
		pl_shift = 1'b0;
		chk("preload_status", {16'h0000, pl_busy, pl_done},
			18'h00001);
		rws = 2'h1;
		xfer(1'b0, 1'b1, 9'h000);
		xfer(1'b0, 1'b1, 9'h001);
		$display("test preload done");
		close_out();
	end
endmodule // tpbr_ram_test
